/* spc_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module spc_checker (
  // Clock, reset and bus
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  // Requests and events
  input wire logic cmp_irq,
  input wire logic ovf_irq,
  input wire logic cmp_evt,
  input wire logic ovf_evt,
  input wire logic wake
);
  wire logic wr = psel & pwrite;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_RDY: assert property (psel && !penable |=> pready) else $error("no ready");
  AST_SRC: assert property (pready |-> $past(psel) && !$past(penable)) else $error("stray ready");
  AST_ONE: assert property (pready |=> !pready) else $error("long ready");
  AST_ERR: assert property (pslverr |-> pready) else $error("lone error");
  AST_CEV: assert property (cmp_evt |=> !cmp_evt) else $error("long cmp event");
  AST_OEV: assert property (ovf_evt |=> !ovf_evt) else $error("long ovf event");
  AST_CIQ: assert property ($fell(cmp_irq) |-> $past(wr) || $past(wr, 2)) else $error("cmp irq lost");
  AST_OIQ: assert property ($fell(ovf_irq) |-> $past(wr) || $past(wr, 2)) else $error("ovf irq lost");
  AST_WAK: assert property (wake |=> !wake) else $error("long wake");
  COV_C: cover property (cmp_evt);
  COV_O: cover property (ovf_evt);
  COV_E: cover property (pslverr);
  COV_W: cover property (wake);
endmodule // spc_checker
bind spc_top spc_checker chk_u (
  .clk     (clk),
  .nrst    (nrst),
  .psel    (psel),
  .penable (penable),
  .pwrite  (pwrite),
  .pready  (pready),
  .pslverr (pslverr),
  .cmp_irq (cmp_irq),
  .ovf_irq (ovf_irq),
  .cmp_evt (cmp_evt),
  .ovf_evt (ovf_evt),
  .wake    (wake)
);
`default_nettype wire

/* spc_map.vh */
// Overview of operation
// [R1] The counter is a 16-bit up-counter with one compare and one period register.
// [R2] Once enabled the counter keeps advancing in active and every sleep mode.
// [R3] Counter events can wake the device, interrupt it at intervals, or both.
// [R4] The reference clock is chosen among crystal 1.024kHz/32.768kHz, external, internal 32.768kHz and ultra_low_power_osc.
// [R5] A programmable 10-bit prescaler divides the reference and counting steps only on its tick.
// [R6] Counter equal to compare raises a compare interrupt request and/or event per enables.
// [R7] Counter equal to period raises an overflow interrupt request and/or event per enables.
// [R8] On period overflow the counter clears to zero and restarts.
// [R9] Compare and period are 16 bits and each comparison uses all 16 counter bits.
`ifndef SPC_MAP_VH
`define SPC_MAP_VH
`define SPC_OFF_CTRL    12'h000
`define SPC_OFF_PRESC   12'h004
`define SPC_OFF_CNT     12'h008
`define SPC_OFF_CMP     12'h00c
`define SPC_OFF_PER     12'h010
`define SPC_OFF_STATUS  12'h014
`define SPC_CTRL_EN     0
`define SPC_CTRL_SEL_LO 1
`define SPC_CTRL_SEL_HI 3
`define SPC_CTRL_CIE    4
`define SPC_CTRL_CEE    5
`define SPC_CTRL_OIE    6
`define SPC_CTRL_OEE    7
`define SPC_CTRL_WCE    8
`define SPC_CTRL_WOE    9
`define SPC_ST_CMP      0
`define SPC_ST_OVF      1
`define SPC_RST_CTRL    10'h000
`define SPC_RST_PRESC   10'h000
`define SPC_RST_CMP     16'hffff
`define SPC_RST_PER     16'hffff
`define SPC_SEL_XTAL1K  3'h0
`define SPC_SEL_XTAL32K 3'h1
`define SPC_SEL_EXT     3'h2
`define SPC_SEL_INT32K  3'h3
`define SPC_SEL_ULP     3'h4
`endif

/* spc_prescaler.v */
`timescale 1ns/1ps
`default_nettype none
`include "spc_map.vh"
// Reference-edge divider: tick every div+1 reference edges
module spc_prescaler #(
  parameter W = 10
) (
  input  wire         clk,
  input  wire         nrst,
  input  wire         run,
  input  wire         ref_edge,
  input  wire [W-1:0] div,
  output reg          tick
);
  reg [W-1:0] cnt_r;
  // [R5] Prescale reference edges
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= {W{1'b0}};
      tick  <= 1'b0;
    end else if (!run) begin
      cnt_r <= {W{1'b0}};
      tick  <= 1'b0;
    end else if (ref_edge) begin
      if (cnt_r >= div) begin
        cnt_r <= {W{1'b0}};
        tick  <= 1'b1;
      end else begin
        cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
        tick  <= 1'b0;
      end
    end else begin
      tick <= 1'b0;
    end
  end
endmodule // spc_prescaler
`default_nettype wire

/* spc_sync.v */
`timescale 1ns/1ps
`default_nettype none
// Two-flop level synchroniser
module spc_sync (
  input  wire clk,
  input  wire nrst,
  input  wire d,
  output reg  q
);
  reg meta_r;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // spc_sync
`default_nettype wire

/* spc_top.v */
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "spc_map.vh"
module spc_top #(
  parameter CW = 16,
  parameter PW = 10
) (
  // Clock and reset
  input  wire        clk,
  input  wire        nrst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Reference clock pins
  input  wire        xtal_1k,
  input  wire        xtal_32k,
  input  wire        ext_clk,
  input  wire        int_osc_32k,
  input  wire        ultra_low_power_osc,
  // Events and requests
  output reg         cmp_irq,
  output reg         ovf_irq,
  output reg         cmp_evt,
  output reg         ovf_evt,
  output reg         wake
);
  reg  [9:0]    ctrl_r;
  reg  [PW-1:0] presc_r;
  reg  [CW-1:0] cnt_r;
  reg  [CW-1:0] cmp_r;
  reg  [CW-1:0] per_r;
  reg  [1:0]    st_r;
  reg           ref_d_r;
  wire [4:0]    ref_s;
  wire          tick;
  reg           ref_sel;
  wire          wr;
  wire          rd;
  wire          hit_cmp;
  wire          hit_ovf;
  wire          en;
  wire [2:0]    sel;
  // Synchronise every reference source
  spc_sync u_s0 (.clk(clk), .nrst(nrst), .d(xtal_1k),             .q(ref_s[0]));
  spc_sync u_s1 (.clk(clk), .nrst(nrst), .d(xtal_32k),            .q(ref_s[1]));
  spc_sync u_s2 (.clk(clk), .nrst(nrst), .d(ext_clk),             .q(ref_s[2]));
  spc_sync u_s3 (.clk(clk), .nrst(nrst), .d(int_osc_32k),         .q(ref_s[3]));
  spc_sync u_s4 (.clk(clk), .nrst(nrst), .d(ultra_low_power_osc), .q(ref_s[4]));
  assign en  = ctrl_r[`SPC_CTRL_EN];
  assign sel = ctrl_r[`SPC_CTRL_SEL_HI:`SPC_CTRL_SEL_LO];
  // [R4] Reference source mux
  always @* begin
    case (sel)
      `SPC_SEL_XTAL1K:  ref_sel = ref_s[0];
      `SPC_SEL_XTAL32K: ref_sel = ref_s[1];
      `SPC_SEL_EXT:     ref_sel = ref_s[2];
      `SPC_SEL_INT32K:  ref_sel = ref_s[3];
      `SPC_SEL_ULP:     ref_sel = ref_s[4];
      default:          ref_sel = 1'b0;
    endcase
  end
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ref_d_r <= 1'b0;
    end else begin
      ref_d_r <= ref_sel;
    end
  end
  // [R5] Prescaled tick
  spc_prescaler #(.W(PW)) u_presc (
    .clk      (clk),
    .nrst     (nrst),
    .run      (en),
    .ref_edge (ref_sel & ~ref_d_r),
    .div      (presc_r),
    .tick     (tick)
  );
  // [R9] Full-width comparisons
  assign hit_cmp = tick && (cnt_r == cmp_r);
  assign hit_ovf = tick && (cnt_r == per_r);
  assign wr = psel & penable & pwrite;
  assign rd = psel & ~penable & ~pwrite;
  // Registers and counter
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r  <= `SPC_RST_CTRL;
      presc_r <= `SPC_RST_PRESC;
      cnt_r   <= {CW{1'b0}};
      cmp_r   <= `SPC_RST_CMP;
      per_r   <= `SPC_RST_PER;
      st_r    <= 2'b00;
    end else begin
      // [R2] Free-running count
      if (en && tick) begin
        // [R8] Clear on period
        if (hit_ovf)
          cnt_r <= {CW{1'b0}};
        // [R1] Up-count
        else
          cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
      end
      if (wr) begin
        case (paddr)
          `SPC_OFF_CTRL:  ctrl_r  <= pwdata[9:0];
          `SPC_OFF_PRESC: presc_r <= pwdata[PW-1:0];
          `SPC_OFF_CNT:   cnt_r   <= pwdata[CW-1:0];
          `SPC_OFF_CMP:   cmp_r   <= pwdata[CW-1:0];
          `SPC_OFF_PER:   per_r   <= pwdata[CW-1:0];
          default:        ;
        endcase
      end
      // Write-one-to-clear, set wins
      st_r[`SPC_ST_CMP] <= (en & hit_cmp) | (st_r[`SPC_ST_CMP] &
                           ~(wr && paddr == `SPC_OFF_STATUS && pwdata[`SPC_ST_CMP]));
      st_r[`SPC_ST_OVF] <= (en & hit_ovf) | (st_r[`SPC_ST_OVF] &
                           ~(wr && paddr == `SPC_OFF_STATUS && pwdata[`SPC_ST_OVF]));
    end
  end
  // Outputs and APB answer
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      cmp_irq <= 1'b0;
      ovf_irq <= 1'b0;
      cmp_evt <= 1'b0;
      ovf_evt <= 1'b0;
      wake    <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel & ~penable) begin
        case (paddr)
          `SPC_OFF_CTRL, `SPC_OFF_PRESC, `SPC_OFF_CNT,
          `SPC_OFF_CMP, `SPC_OFF_PER, `SPC_OFF_STATUS: pslverr <= 1'b0;
          default: pslverr <= 1'b1;
        endcase
      end
      if (rd) begin
        case (paddr)
          `SPC_OFF_CTRL:   prdata <= {{22{1'b0}}, ctrl_r};
          `SPC_OFF_PRESC:  prdata <= {{(32-PW){1'b0}}, presc_r};
          `SPC_OFF_CNT:    prdata <= {{(32-CW){1'b0}}, cnt_r};
          `SPC_OFF_CMP:    prdata <= {{(32-CW){1'b0}}, cmp_r};
          `SPC_OFF_PER:    prdata <= {{(32-CW){1'b0}}, per_r};
          `SPC_OFF_STATUS: prdata <= {{30{1'b0}}, st_r};
          default:         prdata <= 32'h0000_0000;
        endcase
      end
      // [R6] Compare request and event
      cmp_irq <= st_r[`SPC_ST_CMP] & ctrl_r[`SPC_CTRL_CIE];
      cmp_evt <= en & hit_cmp & ctrl_r[`SPC_CTRL_CEE];
      // [R7] Overflow request and event
      ovf_irq <= st_r[`SPC_ST_OVF] & ctrl_r[`SPC_CTRL_OIE];
      ovf_evt <= en & hit_ovf & ctrl_r[`SPC_CTRL_OEE];
      // [R3] Wake-up request
      wake    <= (en & hit_cmp & ctrl_r[`SPC_CTRL_WCE]) | (en & hit_ovf & ctrl_r[`SPC_CTRL_WOE]);
    end
  end
endmodule // spc_top
`default_nettype wire

/* tb_sleep_capable_period_counter.sv */
`timescale 1ns/1ps
`default_nettype none
`include "spc_map.vh"
module tb_sleep_capable_period_counter;
  logic clk = 1'h0, nrst = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic pready, pslverr, cmp_irq, ovf_irq, cmp_evt, ovf_evt, wake, er;
  logic [4:0] refp = 5'h00;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, r;
  wire xtal_1k, xtal_32k, ext_clk, int_osc_32k, ultra_low_power_osc;
  int err_total = 0, check_count = 0, cyc = 0, novf, nwk, ncmp, o0, w0, c0, p, per, cm, n, msk, tk;
  assign {ultra_low_power_osc, int_osc_32k, ext_clk, xtal_32k, xtal_1k} = refp;
  spc_top dut (
    .clk                 (clk),
    .nrst                (nrst),
    .psel                (psel),
    .penable             (penable),
    .pwrite              (pwrite),
    .paddr               (paddr),
    .pwdata              (pwdata),
    .prdata              (prdata),
    .pready              (pready),
    .pslverr             (pslverr),
    .xtal_1k             (xtal_1k),
    .xtal_32k            (xtal_32k),
    .ext_clk             (ext_clk),
    .int_osc_32k         (int_osc_32k),
    .ultra_low_power_osc (ultra_low_power_osc),
    .cmp_irq             (cmp_irq),
    .ovf_irq             (ovf_irq),
    .cmp_evt             (cmp_evt),
    .ovf_evt             (ovf_evt),
    .wake                (wake)
  );
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    novf += ovf_evt;
    ncmp += cmp_evt;
    nwk += wake;
    if (cyc == 20000) begin
      err_total++;
      complete_run;
    end
  end
  task chk(input string nm, input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  // Selected pin slow, neighbour pin twice as fast
  task edges(input int s, input int k);
    repeat (k) for (int j = 0; j < 4; j++) begin
      refp <= ((j < 2) ? 5'h01 << s : 5'h00) | ((j % 2) ? 5'h00 : 5'h01 << ((s + 1) % 5));
      repeat (4) @(posedge clk);
    end
  endtask
  function automatic int exp_of(int t, int ovf);
    return ovf ? t / (p + 1) / (per + 1) : t / (p + 1) % (per + 1);
  endfunction
  // Compare hits among t ticks
  function automatic int cmp_hits(int t);
    return (t + per - cm) / (per + 1);
  endfunction
  // Reset value of register word i
  function automatic logic [31:0] rst_of(int i);
    return (i == 3 || i == 4) ? 32'h0000_ffff : 32'h0000_0000;
  endfunction
  task complete_run;
    if (err_total == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    void'($urandom(32'ha74c_2902));
    repeat (10) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      r = $urandom;
      apb(1'h0, 12'(i * 4), r);
      chk("reset", rd, rst_of(i));
      chk("slverr", 32'(er), 32'(i == 6));
      apb(1'h1, 12'(i * 4), r);
      apb(1'h0, 12'(i * 4), r);
      chk("width", rd, (i > 4) ? 32'h0000_0000 : r & ((i < 2) ? 32'h0000_03ff : 32'h0000_ffff));
    end
    for (int s = 0; s < 5; s++) begin
      p = $urandom % 3;
      per = 3 + $urandom % 4;
      cm = $urandom % per;
      n = (per + 1) * (p + 1) + $urandom % 8;
      msk = (s == 0) ? 32'h0000_03f0 : $urandom & 32'h0000_03f0;
      tk = n / (p + 1);
      apb(1'h1, `SPC_OFF_PRESC, p);
      apb(1'h1, `SPC_OFF_PER, per);
      apb(1'h1, `SPC_OFF_CMP, cm);
      apb(1'h1, `SPC_OFF_CNT, 32'h0000_0000);
      apb(1'h1, `SPC_OFF_STATUS, 32'h0000_0003);
      o0 = novf;
      w0 = nwk;
      c0 = ncmp;
      apb(1'h1, `SPC_OFF_CTRL, 32'h0000_0001 | msk | (s << 1));
      edges(s, n);
      repeat (8) @(posedge clk);
      apb(1'h0, `SPC_OFF_CNT, r);
      chk("count", rd, exp_of(n, 0));
      chk("ovf", novf - o0, msk[7] ? exp_of(n, 1) : 0);
      chk("cmp", ncmp - c0, msk[5] ? cmp_hits(tk) : 0);
      chk("wake", nwk - w0, (msk[8] ? cmp_hits(tk) : 0) + (msk[9] ? exp_of(n, 1) : 0));
      apb(1'h0, `SPC_OFF_STATUS, r);
      chk("status", rd, 32'h0000_0003);
      chk("irq", 32'({cmp_irq, ovf_irq}), 32'({msk[4], msk[6]}));
      apb(1'h1, `SPC_OFF_STATUS, 32'h0000_0003);
      apb(1'h0, `SPC_OFF_STATUS, r);
      chk("clear", rd | 32'({cmp_irq, ovf_irq}), 32'h0000_0000);
      apb(1'h1, `SPC_OFF_CTRL, 32'h0000_0000);
      edges(s, 3);
      apb(1'h0, `SPC_OFF_CNT, r);
      chk("halt", rd, exp_of(n, 0));
    end
    // Unused source codes give no clock
    apb(1'h1, `SPC_OFF_CNT, 32'h0000_0000);
    apb(1'h1, `SPC_OFF_CTRL, 32'h0000_0001 | ((5 + $urandom % 3) << 1));
    for (int s = 0; s < 5; s += 2)
      edges(s, 2);
    apb(1'h0, `SPC_OFF_CNT, r);
    chk("nosrc", rd, 32'h0000_0000);
    // Reset in mid-run
    apb(1'h1, `SPC_OFF_CNT, 32'h0000_0005);
    apb(1'h1, `SPC_OFF_CMP, 32'h0000_0007);
    nrst <= 1'h0;
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      apb(1'h0, 12'(i * 4), r);
      chk("rerun", rd, rst_of(i));
    end
    complete_run;
  end
endmodule // tb_sleep_capable_period_counter
`default_nettype wire
